// ### rtl/mor_map.svh
// Register indices, reset values, codes and timing constants of the modem option bank
`ifndef MOR_MAP_SVH
`define MOR_MAP_SVH
// Register indices (byte address is four times the index)
`define MOR_IDX_V23 5'd0
`define MOR_IDX_FLASH 5'd1
`define MOR_IDX_IDLE 5'd2
`define MOR_IDX_SPEEDREP 5'd3
`define MOR_IDX_RESUME 5'd4
`define MOR_IDX_PAUSE 5'd5
`define MOR_IDX_LINKFAIL 5'd6
`define MOR_IDX_LINESPD 5'd7
`define MOR_IDX_HANGUP 5'd8
`define MOR_IDX_FLOW 5'd9
`define MOR_IDX_LINKSVC 5'd10
`define MOR_IDX_COMPRET 5'd11
`define MOR_IDX_COMPCTL 5'd12
`define MOR_IDX_NEGOT 5'd13
`define MOR_IDX_SWITCH 5'd14
`define MOR_IDX_BREAK 5'd15
`define MOR_IDX_CAUSE 5'd16
`define MOR_IDX_TXLEVEL 5'd17
`define MOR_NREG 18
// Reset values
`define MOR_RST_SPEEDREP 8'h02
`define MOR_RST_RESUME 8'h11
`define MOR_RST_PAUSE 8'h13
`define MOR_RST_LINKFAIL 8'h07
`define MOR_RST_FLOW 8'h03
`define MOR_RST_LINKSVC 8'h69
`define MOR_RST_COMPRET 8'h03
`define MOR_RST_COMPCTL 8'h8A
`define MOR_RST_NEGOT 8'h07
`define MOR_RST_BREAK 8'h80
`define MOR_RST_TXLEVEL 8'h0A
// Field positions
`define MOR_AUTOSPD_BIT 1
`define MOR_PROG_LSB 2
// Codes
`define MOR_COMP_A 8'h88
`define MOR_COMP_B 8'h8A
`define MOR_NEG_CODE_LAPM 8'h00
`define MOR_NEG_CODE_NEG 8'h07
`define MOR_NEG_CODE_FB 8'h80
`define MOR_BRK_CODE_EXP 8'h03
`define MOR_BRK_CODE_DES 8'h07
`define MOR_BRK_CODE_SEQ 8'h80
`define MOR_FAIL_DEFAULT 3'h7
`define MOR_FLOW_DEFAULT 3'h3
`define MOR_FLOW_HW 3'h3
`define MOR_FLOW_BOTH 3'h6
`define MOR_HU_FOREVER 8'hFF
// Timing
`define MOR_CLK_HZ 40000000
`define MOR_TICK_MS 10
`define MOR_TICKS_PER_TENTH 4'd10
`define MOR_TICKS_PER_SEC 7'd100
`endif

// ### rtl/mor_pkg.sv
// Types shared by the modem option register bank
`include "mor_map.svh"
package mor_pkg;
  typedef enum logic [0:0] {MOR_HU_IDLE, MOR_HU_WAIT} mor_hu_e;
  typedef enum logic [1:0] {MOR_NEG_LAPM, MOR_NEG_NEGOTIATE, MOR_NEG_FALLBACK} mor_neg_e;
  typedef enum logic [1:0] {MOR_BRK_EXPEDITED, MOR_BRK_DESTRUCTIVE, MOR_BRK_SEQUENCE} mor_brk_e;
  typedef struct packed {
    logic [`MOR_NREG-1:0][7:0] regs;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [19:0] pre_cnt;
    logic [3:0] tenth_cnt;
    logic [6:0] sec_cnt;
    logic tick;
    logic tick_tenth;
    logic tick_sec;
    logic [7:0] flash_cnt;
    logic on_hook;
    logic [7:0] idle_cnt;
    logic idle_disc;
    mor_hu_e hu_state;
    logic [7:0] hu_cnt;
    logic hu_done;
    logic data_lost;
    logic cause_locked;
    logic link_q;
    logic fallback_now;
    logic auto_speed;
    logic [1:0] progress;
    logic [2:0] fail_action;
    logic [3:0] line_speed;
    logic [2:0] flow;
    logic hw_flow;
    logic [1:0] compress;
    mor_neg_e negot;
    mor_brk_e brk;
    logic [3:0] switches;
  } mor_state_s;
endpackage : mor_pkg

// ### rtl/mor_top.sv
// Modem option register bank with its timers, decoders and APB slave
`timescale 1ns/100ps
`include "mor_map.svh"
// Overview of operation
// - Flash modifier puts line on-hook for count of 10 ms; zero disables.
// - Idle for count of tenths disconnects the call; zero disables.
// - Data restarts the idle timer; timer stopped in synchronous mode.
// - Speed report bit 1 enables automatic line speed detection; reset enables.
// - Progress field: 0 terminal speed, 1 full, 2 line speed; default 0.
// - Resume character is programmable, 17 after reset.
// - Pause character is programmable, 19 after reset.
// - Three-bit link failure action code, default 7.
// - Unsupported fallback, speed or break codes stored, default behaviour used.
// - Negotiation action 128 starts fallback at connection.
// - Four-bit desired speed code selects line rate.
// - Hang-up waits up to delay seconds for buffer; reports loss.
// - Delay 255 never times out; waits for delivery or drop.
// - Hang-up delay applies only to error-correction connections.
// - Three-bit flow control method code, default hardware handshake.
// - Two-bit compression method field, default both.
// - Negotiation code 0 LAPM, 7 negotiate, 128 fallback.
// - Unsupported negotiation code stored but acts as 128.
// - Break code 3 expedited, 7 destructive, 128 in sequence.
// - Lost call cause records only the first contributing event.
// - Four soft switch bits replace four hardware inputs.
// - Compression control accepts only 136 or 138; default 138.
module mor_top
  import mor_pkg::*;
#(
  parameter int TICK_CYCLES = `MOR_CLK_HZ / 1000 * `MOR_TICK_MS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic flash_req,
  input wire logic link_up,
  input wire logic connect_evt,
  input wire logic data_activity,
  input wire logic ec_mode,
  input wire logic sync_mode,
  input wire logic hangup_req,
  input wire logic buf_empty,
  input wire logic fail_valid,
  input wire logic [7:0] fail_code,
  output logic line_on_hook,
  output logic idle_disconnect,
  output logic hangup_done,
  output logic data_lost,
  output logic fallback_now,
  output logic auto_speed_en,
  output logic [1:0] progress_mode,
  output logic [7:0] resume_character,
  output logic [7:0] pause_character,
  output logic [2:0] fail_action,
  output logic [3:0] line_speed,
  output logic [2:0] flow_method,
  output logic hardware_handshake_flow,
  output logic [1:0] compression_select_command,
  output mor_neg_e negot_mode,
  output mor_brk_e break_mode,
  output logic cmd_set_select,
  output logic remote_config_permit,
  output logic callback_security_enable,
  output logic answer_mode
);

  // ******************************
  // Parameter check and reset image
  // ******************************
  localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);

  if (TICK_CYCLES < 2 || TICK_CYCLES > (1 << 20)) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  function automatic mor_state_s mor_rst();
    mor_state_s r;
    r = '0;
    r.regs[`MOR_IDX_SPEEDREP] = `MOR_RST_SPEEDREP;
    r.regs[`MOR_IDX_RESUME] = `MOR_RST_RESUME;
    r.regs[`MOR_IDX_PAUSE] = `MOR_RST_PAUSE;
    r.regs[`MOR_IDX_LINKFAIL] = `MOR_RST_LINKFAIL;
    r.regs[`MOR_IDX_FLOW] = `MOR_RST_FLOW;
    r.regs[`MOR_IDX_LINKSVC] = `MOR_RST_LINKSVC;
    r.regs[`MOR_IDX_COMPRET] = `MOR_RST_COMPRET;
    r.regs[`MOR_IDX_COMPCTL] = `MOR_RST_COMPCTL;
    r.regs[`MOR_IDX_NEGOT] = `MOR_RST_NEGOT;
    r.regs[`MOR_IDX_BREAK] = `MOR_RST_BREAK;
    r.regs[`MOR_IDX_TXLEVEL] = `MOR_RST_TXLEVEL;
    r.auto_speed = 1'b1;
    r.fail_action = `MOR_FAIL_DEFAULT;
    r.flow = `MOR_FLOW_DEFAULT;
    r.hw_flow = 1'b1;
    r.compress = 2'h3;
    r.negot = MOR_NEG_NEGOTIATE;
    r.brk = MOR_BRK_SEQUENCE;
    return r;
  endfunction : mor_rst

  localparam mor_state_s RST_STATE = mor_rst();

  mor_state_s s;
  mor_state_s next_s;
  logic [4:0] idx;
  logic mapped;
  logic wr;

  // Address decode: aligned words below the register count
  assign idx = paddr[6:2];
  assign mapped = (paddr[1:0] == 2'h0) && !paddr[7] && (idx < 5'(`MOR_NREG));
  assign wr = s.pready && psel && penable && pwrite && mapped;

  // ******************************
  // Next-state logic
  // ******************************
  always_comb begin
    logic [7:0] v;
    v = 8'h00;
    next_s = s;
    // APB: answer in the first access cycle, pready for one cycle only
    next_s.pready = psel && !penable;
    next_s.pslverr = psel && !penable && !mapped;
    next_s.prdata = (psel && !penable) ? (mapped ? {24'h0, s.regs[idx]} : 32'h0) : s.prdata;
    // Cause register is read-only; writes to it are dropped silently
    if (wr && idx != `MOR_IDX_CAUSE) begin
      if (idx != `MOR_IDX_COMPCTL || pwdata[7:0] == `MOR_COMP_A
          || pwdata[7:0] == `MOR_COMP_B) begin
        next_s.regs[idx] = pwdata[7:0];
      end
    end

    next_s.tick = 1'b0;
    next_s.tick_tenth = 1'b0;
    next_s.tick_sec = 1'b0;
    if (s.pre_cnt == TICK_LAST) begin
      next_s.pre_cnt = 20'h0;
      next_s.tick = 1'b1;
    end else begin
      next_s.pre_cnt = s.pre_cnt + 20'h1;
    end
    if (s.tick) begin
      next_s.tenth_cnt = (s.tenth_cnt == `MOR_TICKS_PER_TENTH - 4'd1) ? 4'h0 : s.tenth_cnt + 4'h1;
      next_s.sec_cnt = (s.sec_cnt == `MOR_TICKS_PER_SEC - 7'd1) ? 7'h0 : s.sec_cnt + 7'h1;
      next_s.tick_tenth = (s.tenth_cnt == `MOR_TICKS_PER_TENTH - 4'd1);
      next_s.tick_sec = (s.sec_cnt == `MOR_TICKS_PER_SEC - 7'd1);
    end

    if (flash_req && s.regs[`MOR_IDX_FLASH] != 8'h00) begin
      next_s.flash_cnt = s.regs[`MOR_IDX_FLASH];
      next_s.on_hook = 1'b1;
    end else if (s.on_hook && s.tick) begin
      next_s.flash_cnt = s.flash_cnt - 8'h1;
      next_s.on_hook = (s.flash_cnt != 8'h1);
    end

    next_s.idle_disc = 1'b0;
    // stopped when synchronous, restarted by data
    if (!link_up || sync_mode || s.regs[`MOR_IDX_IDLE] == 8'h00) begin
      next_s.idle_cnt = 8'h00;
    end else if (data_activity || (link_up && !s.link_q)) begin
      next_s.idle_cnt = s.regs[`MOR_IDX_IDLE];
      next_s.tenth_cnt = 4'h0;
      next_s.tick_tenth = 1'b0;
    end else if (s.idle_cnt != 8'h00 && s.tick_tenth) begin
      next_s.idle_cnt = s.idle_cnt - 8'h1;
      next_s.idle_disc = (s.idle_cnt == 8'h1);
    end

    next_s.hu_done = 1'b0;
    case (s.hu_state)
      MOR_HU_IDLE: begin
        if (hangup_req) begin
          v = s.regs[`MOR_IDX_HANGUP];
          if (!ec_mode || !link_up || buf_empty) begin
            next_s.hu_done = 1'b1;
            next_s.data_lost = 1'b0;
          end else if (v == 8'h00) begin
            next_s.hu_done = 1'b1;
            next_s.data_lost = 1'b1;
          end else begin
            next_s.hu_cnt = v;
            next_s.sec_cnt = 7'h0;
            next_s.tick_sec = 1'b0;
            next_s.data_lost = 1'b0;
            next_s.hu_state = MOR_HU_WAIT;
          end
        end
      end
      MOR_HU_WAIT: begin
        if (buf_empty || !link_up) begin
          next_s.hu_done = 1'b1;
          next_s.data_lost = !buf_empty;
          next_s.hu_state = MOR_HU_IDLE;
        end else if (s.tick_sec && s.hu_cnt != `MOR_HU_FOREVER) begin
          next_s.hu_cnt = s.hu_cnt - 8'h1;
          if (s.hu_cnt == 8'h1) begin
            next_s.hu_done = 1'b1;
            next_s.data_lost = 1'b1;
            next_s.hu_state = MOR_HU_IDLE;
          end
        end
      end
      default: next_s.hu_state = MOR_HU_IDLE;
    endcase

    // first cause only, rearmed by a new connection
    next_s.link_q = link_up;
    if (fail_valid && (!s.cause_locked || (link_up && !s.link_q))) begin
      next_s.regs[`MOR_IDX_CAUSE] = fail_code;
      next_s.cause_locked = 1'b1;
    end else if (link_up && !s.link_q) begin
      next_s.cause_locked = 1'b0;
    end

    next_s.fallback_now = connect_evt && (s.negot == MOR_NEG_FALLBACK);

    // Decoded views; registered so every output leaves a flip-flop
    // auto speed
    next_s.auto_speed = s.regs[`MOR_IDX_SPEEDREP][`MOR_AUTOSPD_BIT];
    // progress field, undefined 3 treated as default
    v = s.regs[`MOR_IDX_SPEEDREP];
    next_s.progress = (v[`MOR_PROG_LSB+:2] == 2'h3) ? 2'h0 : v[`MOR_PROG_LSB+:2];
    v = s.regs[`MOR_IDX_LINKFAIL];
    next_s.fail_action = (v[2:0] == 3'h2 || v[2:0] == 3'h6) ? `MOR_FAIL_DEFAULT : v[2:0];
    // speed code, reserved values act as automatic
    v = s.regs[`MOR_IDX_LINESPD];
    next_s.line_speed = (v[3:0] == 4'h4 || v[3:0] > 4'hC) ? 4'h0 : v[3:0];
    // flow method, reserved values act as default
    v = s.regs[`MOR_IDX_FLOW];
    next_s.flow = (v[2:0] == 3'h1 || v[2:0] == 3'h2 || v[2:0] == 3'h7)
                ? `MOR_FLOW_DEFAULT : v[2:0];
    next_s.hw_flow = (next_s.flow == `MOR_FLOW_HW) || (next_s.flow == `MOR_FLOW_BOTH);
    next_s.compress = s.regs[`MOR_IDX_COMPRET][1:0];
    // negotiation action; others act as 128
    case (s.regs[`MOR_IDX_NEGOT])
      `MOR_NEG_CODE_LAPM: next_s.negot = MOR_NEG_LAPM;
      `MOR_NEG_CODE_NEG: next_s.negot = MOR_NEG_NEGOTIATE;
      default: next_s.negot = MOR_NEG_FALLBACK;
    endcase
    // break handling; others act as default
    case (s.regs[`MOR_IDX_BREAK])
      `MOR_BRK_CODE_EXP: next_s.brk = MOR_BRK_EXPEDITED;
      `MOR_BRK_CODE_DES: next_s.brk = MOR_BRK_DESTRUCTIVE;
      default: next_s.brk = MOR_BRK_SEQUENCE;
    endcase
    next_s.switches = s.regs[`MOR_IDX_SWITCH][3:0];
  end

  // ******************************
  // State register
  // ******************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= RST_STATE;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign line_on_hook = s.on_hook;
  assign idle_disconnect = s.idle_disc;
  assign hangup_done = s.hu_done;
  assign data_lost = s.data_lost;
  assign fallback_now = s.fallback_now;
  assign auto_speed_en = s.auto_speed;
  assign progress_mode = s.progress;
  assign resume_character = s.regs[`MOR_IDX_RESUME];
  assign pause_character = s.regs[`MOR_IDX_PAUSE];
  assign fail_action = s.fail_action;
  assign line_speed = s.line_speed;
  assign flow_method = s.flow;
  assign hardware_handshake_flow = s.hw_flow;
  assign compression_select_command = s.compress;
  assign negot_mode = s.negot;
  assign break_mode = s.brk;
  assign cmd_set_select = s.switches[0];
  assign remote_config_permit = s.switches[1];
  assign callback_security_enable = s.switches[2];
  assign answer_mode = s.switches[3];

  // ******************************
  // Assertions
  // ******************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_wr_at(logic [4:0] i);
    wr && idx == i;
  endsequence

  property p_flash_zero;
    flash_req && s.regs[`MOR_IDX_FLASH] == 8'h00 && !s.on_hook |=> !line_on_hook;
  endproperty
  a_flash_zero: assert property (p_flash_zero) else $error("flash with zero count");

  property p_idle_sync;
    sync_mode |=> !idle_disconnect;
  endproperty
  a_idle_sync: assert property (p_idle_sync) else $error("idle fired in sync mode");

  property p_auto_speed;
    logic b;
    (s_wr_at(`MOR_IDX_SPEEDREP), b = pwdata[1]) |=> ##1 auto_speed_en == b;
  endproperty
  a_auto_speed: assert property (p_auto_speed) else $error("auto speed not applied");

  property p_resume;
    logic [7:0] d;
    (s_wr_at(`MOR_IDX_RESUME), d = pwdata[7:0]) |=> resume_character == d;
  endproperty
  a_resume: assert property (p_resume) else $error("resume character not stored");

  property p_fail_legal;
    fail_action != 3'h2 && fail_action != 3'h6;
  endproperty
  a_fail_legal: assert property (p_fail_legal) else $error("reserved fallback used");

  property p_fallback;
    connect_evt && s.negot == MOR_NEG_FALLBACK |=> fallback_now;
  endproperty
  a_fallback: assert property (p_fallback) else $error("fallback not started");

  property p_hu_noec;
    s.hu_state == MOR_HU_IDLE && hangup_req && !ec_mode |=> hangup_done && !data_lost;
  endproperty
  a_hu_noec: assert property (p_hu_noec) else $error("non-EC hang-up waited");

  property p_hu_forever;
    s.hu_state == MOR_HU_WAIT && s.hu_cnt == `MOR_HU_FOREVER && !buf_empty && link_up
      |=> !hangup_done;
  endproperty
  a_hu_forever: assert property (p_hu_forever) else $error("delay 255 timed out");

  property p_cause_first;
    s.cause_locked && fail_valid && !(link_up && !s.link_q)
      |=> $stable(s.regs[`MOR_IDX_CAUSE]);
  endproperty
  a_cause_first: assert property (p_cause_first) else $error("cause overwritten");

  property p_compctl;
    s_wr_at(`MOR_IDX_COMPCTL) ##0 (pwdata[7:0] != `MOR_COMP_A && pwdata[7:0] != `MOR_COMP_B)
      |=> $stable(s.regs[`MOR_IDX_COMPCTL]);
  endproperty
  a_compctl: assert property (p_compctl) else $error("bad compression value taken");

endmodule : mor_top

// ### verif/mor_remote.sv
// Remote modem model driving the line-side inputs of the option bank
`timescale 1ns/100ps
module mor_remote (
  input wire logic mclk,
  output logic link_up,
  output logic connect_evt,
  output logic data_activity,
  output logic buf_empty,
  output logic fail_valid,
  output logic [7:0] fail_code
);
  // ****************
  // Line events
  // ****************
  // Quiet line at time zero
  initial begin
    link_up = 0;
    connect_evt = 0;
    data_activity = 0;
    buf_empty = 1;
    fail_valid = 0;
    fail_code = 8'h00;
  end
  // Call comes up with a one-cycle connect pulse
  task automatic connect();
    @(posedge mclk);
    link_up <= 1;
    connect_evt <= 1;
    @(posedge mclk);
    connect_evt <= 0;
  endtask : connect
  task automatic drop();
    @(posedge mclk);
    link_up <= 0;
  endtask : drop
  task automatic set_buf(input logic v);
    @(posedge mclk);
    buf_empty <= v;
  endtask : set_buf
  // Code is not held after the strobe, so stale values cannot pass
  task automatic fail(input logic [7:0] c);
    @(posedge mclk);
    fail_valid <= 1;
    fail_code <= c;
    @(posedge mclk);
    fail_valid <= 0;
    fail_code <= ~c;
  endtask : fail
  // Data bursts k times with g+1 idle cycles between
  task automatic data(input int k, input int g);
    repeat (k) begin
      @(posedge mclk);
      data_activity <= 1;
      @(posedge mclk);
      data_activity <= 0;
      repeat (g) @(posedge mclk);
    end
  endtask : data
endmodule : mor_remote

// ### verif/test_mor_top.sv
// Self-checking bench of the modem option register bank
`timescale 1ns/100ps
module test_mor_top
  import mor_pkg::*;
;
  logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic flash_req = 0, ec_mode = 0, sync_mode = 0, hangup_req = 0;
  logic pready, pslverr, link_up, connect_evt, data_activity, buf_empty, fail_valid;
  logic [7:0] fail_code, resume_character, pause_character;
  logic line_on_hook, idle_disconnect, hangup_done, data_lost, fallback_now;
  logic auto_speed_en, hardware_handshake_flow, cmd_set_select, remote_config_permit;
  logic callback_security_enable, answer_mode;
  logic [1:0] progress_mode, compression_select_command;
  logic [2:0] fail_action, flow_method;
  logic [3:0] line_speed;
  mor_neg_e negot_mode;
  mor_brk_e break_mode;
  int errors = 0, check_count = 0;
  logic [7:0] rst_t [18] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h11, 8'h13, 8'h07, 8'h00, 8'h00,
    8'h03, 8'h69, 8'h03, 8'h8A, 8'h07, 8'h00, 8'h80, 8'h00, 8'h0A};
  logic [7:0] sh [18];
  // Short tick keeps second-long waits within a few hundred cycles
  mor_top #(.TICK_CYCLES(4)) DUT (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .flash_req, .link_up, .connect_evt, .data_activity,
    .ec_mode, .sync_mode, .hangup_req, .buf_empty, .fail_valid, .fail_code, .line_on_hook,
    .idle_disconnect, .hangup_done, .data_lost, .fallback_now, .auto_speed_en,
    .progress_mode, .resume_character, .pause_character, .fail_action, .line_speed,
    .flow_method, .hardware_handshake_flow, .compression_select_command, .negot_mode,
    .break_mode, .cmd_set_select, .remote_config_permit, .callback_security_enable,
    .answer_mode);
  mor_remote u_rem (.mclk, .link_up, .connect_evt, .data_activity, .buf_empty,
    .fail_valid, .fail_code);
  // 40 MHz clock
  always #12.5 mclk = ~mclk;
  // ****************
  // Checks and bus
  // ****************
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // Request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int n;
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 40) begin
      errors++;
      complete_run();
    end
  endtask : apb
  // Shadow keeps read-only cause and refused compression codes
  task automatic wr(input int i, input logic [7:0] v);
    logic [31:0] q;
    logic e;
    apb(1, 8'(i * 4), {24'($urandom), v}, q, e);
    chk(e, 0);
    if (i != 16 && (i != 12 || v == 8'h88 || v == 8'h8A)) sh[i] = v;
  endtask : wr
  task automatic rd(input int i, output logic [31:0] q);
    logic e;
    apb(0, 8'(i * 4), 32'h0, q, e);
    chk(e, 0);
  endtask : rd
  function automatic logic sg(input int s);
    case (s)
      0: return line_on_hook;
      1: return !line_on_hook;
      2: return hangup_done;
      3: return idle_disconnect;
      default: return fallback_now;
    endcase
  endfunction : sg
  // Cycles until the event, lim when it never came
  task automatic wait_sig(input int s, input int lim, output int n);
    n = 0;
    @(negedge mclk);
    while (n < lim && sg(s) !== 1'b1) begin
      @(negedge mclk);
      n++;
    end
  endtask : wait_sig
  task automatic pulse(input logic h);
    @(posedge mclk);
    if (h) hangup_req <= 1;
    else flash_req <= 1;
    @(posedge mclk);
    hangup_req <= 0;
    flash_req <= 0;
  endtask : pulse
  function automatic logic [2:0] e_flow(input logic [7:0] v);
    return (v[2:0] inside {3'h1, 3'h2, 3'h7}) ? 3'h3 : v[2:0];
  endfunction : e_flow
  task automatic chk_dec();
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    // Decoded option outputs
    chk(auto_speed_en, sh[3][1]);
    chk(progress_mode, sh[3][3:2] == 2'h3 ? 2'h0 : sh[3][3:2]);
    chk({pause_character, resume_character}, {sh[5], sh[4]});
    chk(fail_action, sh[6][2:0] inside {3'h2, 3'h6} ? 3'h7 : sh[6][2:0]);
    chk(line_speed, sh[7][3:0] inside {4'h4, [4'hD:4'hF]} ? 4'h0 : sh[7][3:0]);
    chk(flow_method, e_flow(sh[9]));
    chk(hardware_handshake_flow, e_flow(sh[9]) inside {3'h3, 3'h6});
    chk(compression_select_command, sh[11][1:0]);
    chk(negot_mode, sh[13] == 8'h00 ? MOR_NEG_LAPM : sh[13] == 8'h07 ?
      MOR_NEG_NEGOTIATE : MOR_NEG_FALLBACK);
    chk(break_mode, sh[15] == 8'h03 ? MOR_BRK_EXPEDITED : sh[15] == 8'h07 ?
      MOR_BRK_DESTRUCTIVE : MOR_BRK_SEQUENCE);
    chk({answer_mode, callback_security_enable, remote_config_permit, cmd_set_select},
      sh[14][3:0]);
  endtask : chk_dec
  // ****************
  // Main sequence
  // ****************
  initial begin
    logic [31:0] q;
    logic e;
    int n;
    void'($urandom(32'hcd21));
    sh = rst_t;
    repeat (3) @(posedge mclk);
    rst <= 0;
    // Reset values, then unmapped places refused
    for (int i = 0; i < 18; i++) begin
      rd(i, q);
      chk(q, rst_t[i]);
    end
    chk_dec();
    foreach (rst_t[i]) if (i < 4) begin
      apb(i[0], i[1] ? 8'h48 : 8'h81, 32'hFF, q, e);
      chk({e, q}, {1'b1, 32'h0});
    end
    // Random contents with every code forced in turn
    for (int i = 0; i < 16; i++) begin
      wr(3, 8'($urandom));
      wr(4, 8'($urandom));
      wr(5, 8'($urandom));
      wr(6, {5'($urandom), 3'(i)});
      wr(7, {4'($urandom), 4'(i)});
      wr(9, {5'($urandom), 3'(i)});
      wr(11, 8'($urandom));
      wr(14, 8'($urandom));
      wr(12, i[0] ? 8'($urandom) : (i[1] ? 8'h88 : 8'h8A));
      wr(13, i % 4 == 0 ? 8'h00 : i % 4 == 1 ? 8'h07 : i % 4 == 2 ? 8'h80 : 8'($urandom) | 8'h08);
      wr(15, i % 4 == 0 ? 8'h03 : i % 4 == 1 ? 8'h07 : i % 4 == 2 ? 8'h80 : 8'($urandom) | 8'h08);
      wr(16, 8'($urandom));
      ec_mode <= 1'($urandom);
      sync_mode <= 1'($urandom);
      chk_dec();
      for (int k = 0; k < 18; k++) begin
        rd(k, q);
        chk(q, sh[k]);
      end
    end
    ec_mode <= 0;
    sync_mode <= 0;
    // Flash of two ticks, then a zero count
    wr(1, 8'h02);
    pulse(0);
    wait_sig(0, 2, n);
    chk(n, 0);
    wait_sig(1, 20, n);
    chk(n >= 3 && n <= 9, 1);
    wr(1, 8'h00);
    pulse(0);
    wait_sig(0, 12, n);
    chk(n, 12);
    // Non-error-correction hang-up is immediate
    wr(8, 8'h01);
    pulse(1);
    wait_sig(2, 2, n);
    chk(n, 0);
    // One second wait runs out with data pending
    u_rem.connect();
    ec_mode <= 1;
    u_rem.set_buf(0);
    pulse(1);
    wait_sig(2, 600, n);
    chk({n >= 380 && n <= 410, data_lost}, 2'b11);
    // Never times out; ends on delivery or drop
    wr(8, 8'hFF);
    pulse(1);
    wait_sig(2, 700, n);
    chk(n, 700);
    u_rem.set_buf(1);
    wait_sig(2, 4, n);
    chk({n < 4, data_lost}, 2'b10);
    u_rem.set_buf(0);
    pulse(1);
    u_rem.drop();
    wait_sig(2, 4, n);
    chk({n < 4, data_lost}, 2'b11);
    // Idle timer: traffic holds it off, sync mode stops it
    u_rem.connect();
    wr(2, 8'h01);
    fork
      u_rem.data(6, 20);
      wait_sig(3, 120, n);
    join
    chk(n, 120);
    wait_sig(3, 60, n);
    chk(n < 60, 1);
    @(posedge mclk);
    sync_mode <= 1;
    fork
      u_rem.data(1, 0);
      wait_sig(3, 120, n);
    join
    chk(n, 120);
    // Only the first cause of a call is kept
    u_rem.drop();
    u_rem.connect();
    u_rem.fail(8'h04);
    u_rem.fail(8'h0D);
    rd(16, q);
    chk(q, 32'h04);
    u_rem.drop();
    u_rem.connect();
    u_rem.fail(8'h0C);
    rd(16, q);
    chk(q, 32'h0C);
    // Fallback pulse at connection for code 128, none for code 7
    for (int i = 0; i < 2; i++) begin
      wr(13, i ? 8'h07 : 8'h80);
      u_rem.drop();
      fork
        u_rem.connect();
        wait_sig(4, 4, n);
      join
      chk(n < 4, !i);
    end
    complete_run();
  end
endmodule : test_mor_top
